// [nibble_delay_counter.v]
// Down-counter that signals the end of a programmed wait
`timescale 1ns/10ps
module nibble_delay_counter #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire reset_n,
  input wire load,
  input wire [WIDTH-1:0] load_value,
  output wire expired
);
  reg [WIDTH-1:0] count;
  assign expired = (count == {WIDTH{1'b0}});
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {WIDTH{1'b0}};
    end else if (load) begin
      count <= load_value;
    end else if (!expired) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// [nibble_expander_model.sv]
// Behavioural model of the port expander on the far side of the nibble bus
`timescale 1ns/10ps
module nibble_expander_model(
  input wire strobe,
  input wire unit_select,
  input wire [3:0] bus_in,
  input wire [15:0] pin_in,
  output wire [3:0] bus_drive,
  output wire bus_drive_en,
  output wire [15:0] pins
);
  reg [3:0] latch [0:3];
  reg [3:0] out_mode = 4'h0;
  reg [3:0] inst = 4'h0;
  wire prog = strobe | unit_select;
  genvar g;
  for (g = 0; g < 4; g = g + 1) begin : g_pin
    assign pins[g*4 +: 4] = out_mode[g] ? latch[g] : pin_in[g*4 +: 4];
  end
  assign bus_drive_en = !prog && inst[3:2] == 2'h0;
  assign bus_drive = pins[inst[1:0]*4 +: 4];
  always @(negedge prog) begin
    inst = bus_in;
    if (bus_in[3:2] == 2'h0) out_mode[bus_in[1:0]] = 1'b0;
  end
  always @(posedge prog) begin
    case (inst[3:2])
      2'h1: latch[inst[1:0]] = bus_in;
      2'h2: latch[inst[1:0]] = latch[inst[1:0]] | bus_in;
      2'h3: latch[inst[1:0]] = latch[inst[1:0]] & bus_in;
      default: ;
    endcase
    if (inst[3:2] != 2'h0) out_mode[inst[1:0]] = 1'b1;
  end
endmodule

// [nibble_host_checker.sv]
// Concurrent checks on the nibble-bus host controller ports
`timescale 1ns/10ps
module nibble_host_checker(
  input wire clk,
  input wire reset_n,
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [1:0] cmd_port,
  input wire cmd_ready,
  input wire rsp_valid,
  input wire strobe,
  input wire unit_select,
  input wire [3:0] nibble_bus_out,
  input wire nibble_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  reg rd;
  // Remembers whether the transfer in flight is a read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) rd <= 1'b0;
    else if (cmd_valid && cmd_ready) rd <= (cmd_op == 2'h0);
  end
  a_take_opcode: assert property (cmd_valid && cmd_ready |=> !unit_select && nibble_bus_oe
    && nibble_bus_out == {$past(cmd_op), $past(cmd_port)}) else $error("opcode not driven");
  a_opcode_hold: assert property ($fell(strobe) |-> nibble_bus_oe && $stable(nibble_bus_out))
    else $error("opcode hold short");
  a_sel_setup: assert property ($fell(strobe) |-> !unit_select && !$past(unit_select))
    else $error("select late");
  a_opcode_setup: assert property ($fell(strobe) |-> $past(nibble_bus_oe, 2)
    && $past(nibble_bus_out) == $past(nibble_bus_out, 2)) else $error("opcode setup short");
  a_strobe_width: assert property ($fell(strobe) |-> !strobe [*7])
    else $error("strobe low too short");
  a_strobe_end: assert property ($fell(strobe) |-> ##[1:20] strobe) else $error("strobe stuck");
  a_read_release: assert property (!strobe && !$past(strobe) && rd |-> !nibble_bus_oe)
    else $error("host drives bus in read");
  a_write_data: assert property (!strobe && !rd && !unit_select |-> nibble_bus_oe)
    else $error("write data missing");
  a_data_hold: assert property ($rose(strobe) && !rd |-> nibble_bus_oe && !unit_select
    && $stable(nibble_bus_out)) else $error("data hold short");
  a_rsp_pulse: assert property (rsp_valid |-> strobe ##1 !rsp_valid) else $error("rsp pulse");
  a_ready_idle: assert property (cmd_ready |-> strobe && unit_select && !nibble_bus_oe)
    else $error("ready while busy");
  c_read: cover property (rsp_valid);
  c_write: cover property ($fell(strobe) && !rd);
  c_and: cover property (cmd_valid && cmd_ready && cmd_op == 2'h3);
  c_dummy: cover property (rd && $rose(unit_select) ##1 $fell(unit_select));
endmodule
bind nibble_strobe_host nibble_host_checker i_chk(.clk(clk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_port(cmd_port), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .strobe(strobe), .unit_select(unit_select),
  .nibble_bus_out(nibble_bus_out), .nibble_bus_oe(nibble_bus_oe));

// [nibble_host_defines.vh]
// Constants for the nibble-bus expander host controller
`ifndef NIBBLE_HOST_DEFINES_VH
`define NIBBLE_HOST_DEFINES_VH
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_OR_MERGE 2'h2
`define OP_AND_MERGE 2'h3
`define CLK_PERIOD_NS 100
`define READY_TIME_US 500
`define SETUP_TIME_NS 200
`define HOLD_TIME_NS 100
`define STROBE_LOW_NS 700
`define ACCESS_TIME_NS 650
`define SEL_SETUP_NS 50
`define CNT_W 16
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000
`define SYNC_STAGES 16'h0002
`define PORT_MODE_UNKNOWN 4'hf
`endif

// [nibble_strobe_host.v]
// Host controller that drives the nibble-bus port expander through its pins
// Overview of operation
// - Upper bits: 00 read, 01 write, 10 OR, 11 AND; lower bits port.
// - Host samples bus while strobe still low, then raises strobe.
// - Host puts data on bus after falling edge, raises strobe once valid.
// - Host waits about 500 us after power-up before any strobe.
// - Host does a dummy read when a port leaves output mode.
`timescale 1ns/10ps
`include "nibble_host_defines.vh"
module nibble_strobe_host #(
  parameter POWER_UP_CYCLES = (`READY_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire reset_n,
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [1:0] cmd_port,
  input wire [3:0] cmd_data,
  output wire cmd_ready,
  output reg rsp_valid,
  output reg [3:0] rsp_data,
  output reg strobe,
  output reg unit_select,
  input wire [3:0] nibble_bus_in,
  output reg [3:0] nibble_bus_out,
  output reg nibble_bus_oe
);
  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  // Rounds up and never gives zero, so every wait lasts at least a cycle
  function [`CNT_W-1:0] cycles_up;
    input integer ns;
    integer t;
    begin
      t = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      if (t < 1) begin
        t = 1;
      end
      cycles_up = t[`CNT_W-1:0];
    end
  endfunction
  localparam [`CNT_W-1:0] SEL_CYC = cycles_up(`SEL_SETUP_NS);
  localparam [`CNT_W-1:0] SETUP_CYC = cycles_up(`SETUP_TIME_NS);
  localparam [`CNT_W-1:0] HOLD_CYC = cycles_up(`HOLD_TIME_NS);
  localparam [`CNT_W-1:0] LOW_CYC = cycles_up(`STROBE_LOW_NS);
  localparam [`CNT_W-1:0] ACC_CYC = cycles_up(`ACCESS_TIME_NS);
  localparam [`CNT_W-1:0] PWR_CYC = cycles_up(POWER_UP_CYCLES * `CLK_PERIOD_NS);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [7:0] S_POWER = 8'h01;
  localparam [7:0] S_IDLE = 8'h02;
  localparam [7:0] S_SELECT = 8'h04;
  localparam [7:0] S_ADDR = 8'h08;
  localparam [7:0] S_LOW = 8'h10;
  localparam [7:0] S_SAMPLE = 8'h20;
  localparam [7:0] S_HOLD = 8'h40;
  localparam [7:0] S_DONE = 8'h80;

  reg [7:0] state;
  reg [7:0] next_state;
  reg [1:0] op;
  reg [1:0] port;
  reg [3:0] data;
  reg [3:0] bus_sync1;
  reg [3:0] bus_sync2;
  reg load;
  reg [`CNT_W-1:0] load_value;
  wire expired;
  reg pwr_armed;
  reg hold_inst;
  reg dummy;
  reg [3:0] port_out;

  nibble_delay_counter #(.WIDTH(`CNT_W)) delay (
    .clk(clk),
    .reset_n(reset_n),
    .load(load),
    .load_value(load_value),
    .expired(expired)
  );

  // Ready only in idle, so a command is taken in one cycle
  assign cmd_ready = (state == S_IDLE);

  // Returned nibble crosses from the pins, so two stages first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_sync1 <= 4'h0;
      bus_sync2 <= 4'h0;
    end else begin
      bus_sync1 <= nibble_bus_in;
      bus_sync2 <= bus_sync1;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    load = 1'b0;
    load_value = `CNT_ZERO;
    case (state)
      S_POWER: begin
        if (!pwr_armed) begin
          load = 1'b1;
          load_value = PWR_CYC;
        end else if (expired) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (cmd_valid) begin
          next_state = S_SELECT;
          load = 1'b1;
          load_value = SEL_CYC;
        end
      end
      S_SELECT: begin
        if (expired) begin
          next_state = S_ADDR;
          load = 1'b1;
          load_value = SETUP_CYC;
        end
      end
      S_ADDR: begin
        if (expired) begin
          next_state = S_LOW;
          load = 1'b1;
          // Read waits access time plus two sync stages
          load_value = (op == `OP_READ) ? ACC_CYC + `SYNC_STAGES : LOW_CYC;
        end
      end
      S_LOW: begin
        if (expired) begin
          next_state = (op == `OP_READ) ? S_SAMPLE : S_HOLD;
          load = 1'b1;
          load_value = HOLD_CYC;
        end
      end
      S_SAMPLE: begin
        next_state = S_HOLD;
        load = 1'b1;
        load_value = HOLD_CYC;
      end
      S_HOLD: begin
        if (expired) begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        if (dummy) begin
          next_state = S_SELECT;
          load = 1'b1;
          load_value = SEL_CYC;
        end else begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_POWER;
    end else begin
      state <= next_state;
    end
  end

  // Power-up wait is loaded once right after reset release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_armed <= 1'b0;
    end else begin
      pwr_armed <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Pin and response registers
  // ------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op <= 2'h0;
      port <= 2'h0;
      data <= 4'h0;
      strobe <= 1'b1;
      unit_select <= 1'b1;
      nibble_bus_out <= 4'h0;
      nibble_bus_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 4'h0;
      hold_inst <= 1'b0;
      dummy <= 1'b0;
      // Expander keeps its modes across our reset, so assume every port may be an output
      port_out <= `PORT_MODE_UNKNOWN;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            op <= cmd_op;
            port <= cmd_port;
            data <= cmd_data;
            unit_select <= 1'b0;
            nibble_bus_out <= {cmd_op, cmd_port};
            nibble_bus_oe <= 1'b1;
            dummy <= (cmd_op == `OP_READ) && port_out[cmd_port];
            port_out[cmd_port] <= (cmd_op != `OP_READ);
          end
        end
        S_ADDR: begin
          if (expired) begin
            strobe <= 1'b0;
            hold_inst <= 1'b1;
          end
        end
        S_LOW: begin
          hold_inst <= 1'b0;
          // Opcode stays one cycle past the fall to meet the expander's hold time
          if (hold_inst) begin
            if (op == `OP_READ) begin
              nibble_bus_oe <= 1'b0;
            end else begin
              nibble_bus_out <= data;
            end
          end
          if (expired && op != `OP_READ) begin
            strobe <= 1'b1;
          end
        end
        S_SAMPLE: begin
          rsp_data <= bus_sync2;
          strobe <= 1'b1;
        end
        S_HOLD: begin
          if (expired) begin
            nibble_bus_oe <= 1'b0;
            unit_select <= 1'b1;
          end
        end
        S_DONE: begin
          if (dummy) begin
            // Throwaway read done; repeat it now that the port has turned around
            dummy <= 1'b0;
            unit_select <= 1'b0;
            nibble_bus_out <= {op, port};
            nibble_bus_oe <= 1'b1;
          end else begin
            rsp_valid <= (op == `OP_READ);
          end
        end
        default: begin
          strobe <= 1'b1;
        end
      endcase
    end
  end

endmodule

// [tb.sv]
// Self-checking bench: host controller against the expander model
`timescale 1ns/10ps
`define CHECK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
  n_mismatch = n_mismatch + 1; $display("Error at %0t: got %h exp %h", $time, a, b); end end
module tb;
  reg clk = 0;
  reg reset_n = 0;
  reg cmd_valid = 0;
  reg [1:0] cmd_op = 0;
  reg [1:0] cmd_port = 0;
  reg [3:0] cmd_data = 0;
  reg [3:0] idle = 4'h0;
  wire cmd_ready, rsp_valid, strobe, unit_select, nibble_bus_oe, drv_en;
  wire [3:0] rsp_data, nibble_bus_out, drv, bus;
  wire [15:0] pins;
  wire [15:0] pin_in = 16'h3c5a;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer i;
  // Host assumes unknown port modes after its reset, so first reads are doubled
  reg [3:0] port_mode = 4'hf;
  integer n_fall = 0;
  integer n_rsp = 0;
  always @(negedge strobe) n_fall = n_fall + 1;
  always @(posedge rsp_valid) n_rsp = n_rsp + 1;
  // Rows: {op, port, data, expected port or read value}
  localparam [155:0] ROWS = {12'h00a, 12'h466, 12'h89f, 12'hc55, 12'h00a, 12'h533, 12'hd62,
    12'h6ee, 12'ha1f, 12'h788, 12'h303, 12'h105, 12'h20c};
  // Released bus shows a changing pattern, not the last driven value
  assign bus = nibble_bus_oe ? nibble_bus_out : (drv_en ? drv : idle);
  always @(posedge clk) idle <= ~bus;
  nibble_strobe_host #(.POWER_UP_CYCLES(20)) i_dut(.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_port(cmd_port), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .strobe(strobe),
    .unit_select(unit_select), .nibble_bus_in(bus), .nibble_bus_out(nibble_bus_out),
    .nibble_bus_oe(nibble_bus_oe));
  nibble_expander_model i_exp(.strobe(strobe), .unit_select(unit_select), .bus_in(bus),
    .pin_in(pin_in), .bus_drive(drv), .bus_drive_en(drv_en), .pins(pins));
  task wait_ready;
    integer k;
    begin
      k = 0;
      while (cmd_ready !== 1'b1 && k < 100) begin
        @(negedge clk);
        k = k + 1;
      end
      `CHECK(cmd_ready, 1'b1)
    end
  endtask
  task run_cmd(input [11:0] r);
    integer f0;
    integer v0;
    integer exp_f;
    begin
      exp_f = (r[11:10] == 2'h0 && port_mode[r[9:8]]) ? 2 : 1;
      wait_ready;
      f0 = n_fall;
      v0 = n_rsp;
      @(posedge clk);
      cmd_op <= r[11:10];
      cmd_port <= r[9:8];
      cmd_data <= r[7:4];
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
      wait_ready;
      `CHECK(pins[r[9:8]*4 +: 4], r[3:0])
      if (r[11:10] == 2'h0) `CHECK(rsp_data, r[3:0])
      `CHECK(n_fall - f0, exp_f)
      `CHECK(n_rsp - v0, (r[11:10] == 2'h0) ? 1 : 0)
      port_mode[r[9:8]] = (r[11:10] != 2'h0);
    end
  endtask
  task summarize;
    begin
      $display("Checks: %0d, mismatches: %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial forever #50 clk = ~clk;
  initial begin
    #(3000 * 100);
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (15) @(negedge clk);
    `CHECK(cmd_ready, 1'b0)
    wait_ready;
    `CHECK(pins, pin_in)
    for (i = 0; i < 13; i = i + 1) run_cmd(ROWS[(12 - i)*12 +: 12]);
    // Reset during a write's opcode setup, before strobe falls, must leave strobe high, raise select, release the bus and drop ready
    @(posedge clk);
    cmd_op <= 2'h1;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (4) @(negedge clk);
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    `CHECK({strobe, unit_select, nibble_bus_oe, cmd_ready}, 4'b1100)
    @(posedge clk);
    reset_n <= 1'b1;
    port_mode = 4'hf;
    repeat (15) @(negedge clk);
    `CHECK(cmd_ready, 1'b0)
    run_cmd(12'h788);
    run_cmd(12'h303);
    summarize;
  end
endmodule
